// *** hw/pdmc_power_down_ctrl.sv ***
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Function
// - Sleep instruction, standby select 0: sleep
// - Sleep keeps clock and peripherals running
// - Standby select 1: clock, peripherals halt
// - RAM contents kept in sleep, standby
// - Sleep exits: NMI, interrupt, DMA error, reset
// - Accepted interrupt wakes, starts exception
// - Masked or disabled interrupts never wake
// - DMA address error wakes with exception
// - Reset pin low ends sleep
// - Standby exits only by NMI or reset
// - Standby select blocked while watchdog runs
// - Port float blocked while watchdog runs
// - Ports float in standby only if selected
// - Control register 8 bits, resets 1F
// - Bit 5 reads zero, written zero
// - Bits 4..0 read one, written one
module pdmc_power_down_ctrl
  import pdmc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // CPU, interrupt controller and watchdog
  pdmc_if.dev       bus,
  // Pins and chip-level controls
  input  wire logic resetPinN,
  output logic      clockRun,
  output logic      periphRun,
  output logic      portFloat,
  output logic      ramHold
);

  pdmc_mode_t mode;
  pdmc_mode_t next_mode;
  logic       resetPinSync;
  logic       porHit;
  logic       standbySel;
  logic       portFloatSel;
  logic       regHit;
  logic       irqWake;
  logic [7:0] pdcValue;
  logic       next_excIrq;
  logic       next_excDma;
  logic       next_excNmi;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin

  pdmc_sync3 #(
    .INIT (1'b1)
  ) pdmc_sync3_inst (
    .clk  (clk),
    .nrst (nrst),
    .din  (resetPinN),
    .dout (resetPinSync)
  );

  assign porHit = !resetPinSync;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  assign regHit = (bus.regAddr == PDC_OFFSET);

  assign pdcValue = {standbySel, portFloatSel, PDC_BIT5, PDC_ONES};

  // Register write and reset to 1F
  always_ff @(posedge clk)
  begin
    if (!nrst || porHit)
    begin
      standbySel   <= PDC_RESET[PDC_STBY_BIT];
      portFloatSel <= PDC_RESET[PDC_FLOAT_BIT];
    end
    else if (bus.regWr && regHit)
    begin
      standbySel   <= bus.regWdata[PDC_STBY_BIT]
                      && (!bus.watchdogRun || standbySel);
      portFloatSel <= bus.regWdata[PDC_FLOAT_BIT]
                      && (!bus.watchdogRun || portFloatSel);
    end
  end

  // Read data valid for one cycle only; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      bus.regRdata <= 8'h00;
    else if (bus.regRd && regHit)
      bus.regRdata <= pdcValue;
    else
      bus.regRdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing

  // Priority above mask and source enabled
  assign irqWake = bus.irqReq && bus.irqEnabled
                   && (bus.irqPrio > bus.cpuMask);

  always_comb
  begin
    next_mode   = mode;
    next_excIrq = 1'b0;
    next_excDma = 1'b0;
    next_excNmi = 1'b0;
    unique case (mode)
      PDMC_RUN:
      begin
        if (bus.sleepExec)
        begin
          if (standbySel)
            next_mode = PDMC_STANDBY;
          else
            next_mode = PDMC_SLEEP;
        end
      end
      PDMC_SLEEP:
      begin
        // NMI first, then DMA error, then interrupt
        if (bus.nmiReq)
        begin
          next_mode   = PDMC_RUN;
          next_excNmi = 1'b1;
        end
        else if (bus.dmaAddrErr)
        begin
          next_mode   = PDMC_RUN;
          next_excDma = 1'b1;
        end
        else if (irqWake)
        begin
          next_mode   = PDMC_RUN;
          next_excIrq = 1'b1;
        end
      end
      PDMC_STANDBY:
      begin
        if (bus.nmiReq)
        begin
          next_mode   = PDMC_RUN;
          next_excNmi = 1'b1;
        end
      end
    endcase
  end

  // Reset pin returns to program execution
  always_ff @(posedge clk)
  begin
    if (!nrst || porHit)
      mode <= PDMC_RUN;
    else
      mode <= next_mode;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || porHit)
    begin
      bus.excIrq <= 1'b0;
      bus.excDma <= 1'b0;
      bus.excNmi <= 1'b0;
    end
    else
    begin
      bus.excIrq <= next_excIrq;
      bus.excDma <= next_excDma;
      bus.excNmi <= next_excNmi;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      bus.porActive <= 1'b0;
    else
      bus.porActive <= porHit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs, registered from the next mode

  always_ff @(posedge clk)
  begin
    if (!nrst || porHit)
    begin
      bus.cpuHalt       <= 1'b0;
      bus.standbyActive <= 1'b0;
      clockRun          <= 1'b1;
      periphRun         <= 1'b1;
      ramHold           <= 1'b0;
    end
    else
    begin
      // CPU halts in either low-power mode
      bus.cpuHalt       <= (next_mode != PDMC_RUN);
      bus.standbyActive <= (next_mode == PDMC_STANDBY);
      // Clock and peripherals stop in standby only
      clockRun          <= (next_mode != PDMC_STANDBY);
      periphRun         <= (next_mode != PDMC_STANDBY);
      ramHold           <= (next_mode != PDMC_RUN);
    end
  end

  // Float needs the select bit; sleep always holds the pins
  always_ff @(posedge clk)
  begin
    if (!nrst || porHit)
      portFloat <= 1'b0;
    else
      // Float only in standby with select set
      portFloat <= (next_mode == PDMC_STANDBY) && portFloatSel;
  end

endmodule // pdmc_power_down_ctrl

// *** hw/pdmc_pkg.sv ***
package pdmc_pkg;

  // Power-down control register on the device side
  localparam logic [31:0] PDC_OFFSET    = 32'hFFFF8614;
  localparam logic [7:0]  PDC_RESET     = 8'h1F;
  localparam int          PDC_STBY_BIT  = 7;
  localparam int          PDC_FLOAT_BIT = 6;
  localparam logic [4:0]  PDC_ONES      = 5'h1F;
  localparam logic        PDC_BIT5      = 1'b0;

  // Controller registers on the CPU side
  localparam logic [7:0]  HOST_WDOG_OFS = 8'h00;
  localparam logic [7:0]  HOST_MASK_OFS = 8'h04;
  localparam logic [7:0]  HOST_CMD_OFS  = 8'h08;
  localparam logic [7:0]  HOST_PDC_OFS  = 8'h0C;
  localparam logic [7:0]  HOST_STAT_OFS = 8'h10;

  // Command and mask register fields
  localparam int CMD_SLEEP_BIT = 0;
  localparam int CMD_IRQ_BIT   = 1;
  localparam int CMD_NMI_BIT   = 2;
  localparam int CMD_DMAE_BIT  = 3;
  localparam int CMD_PRIO_LSB  = 4;
  localparam int MASK_EN_BIT   = 4;

  // Status register fields
  localparam int STAT_IRQ_BIT  = 0;
  localparam int STAT_DMAE_BIT = 1;
  localparam int STAT_NMI_BIT  = 2;

  // Synchroniser length for pin inputs
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    PDMC_RUN,
    PDMC_SLEEP,
    PDMC_STANDBY
  } pdmc_mode_t;

endpackage

// *** hw/pdmc_if.sv ***
`timescale 1ns/1ps
interface pdmc_if;
  // Register access
  logic [31:0] regAddr;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regWdata;
  logic [7:0]  regRdata;
  // CPU, interrupt and watchdog events
  logic        sleepExec;
  logic        irqReq;
  logic [3:0]  irqPrio;
  logic        irqEnabled;
  logic [3:0]  cpuMask;
  logic        nmiReq;
  logic        dmaAddrErr;
  logic        watchdogRun;
  // Mode and wake reports
  logic        cpuHalt;
  logic        standbyActive;
  logic        porActive;
  logic        excIrq;
  logic        excDma;
  logic        excNmi;

  modport dev (
    input  regAddr, regWr, regRd, regWdata, sleepExec, irqReq, irqPrio,
    input  irqEnabled, cpuMask, nmiReq, dmaAddrErr, watchdogRun,
    output regRdata, cpuHalt, standbyActive, porActive,
    output excIrq, excDma, excNmi
  );

  modport host (
    output regAddr, regWr, regRd, regWdata, sleepExec, irqReq, irqPrio,
    output irqEnabled, cpuMask, nmiReq, dmaAddrErr, watchdogRun,
    input  regRdata, cpuHalt, standbyActive, porActive,
    input  excIrq, excDma, excNmi
  );
endinterface

// *** hw/pdmc_sync3.sv ***
`timescale 1ns/1ps
module pdmc_sync3
  import pdmc_pkg::*;
#(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin and filtered level
  input  wire logic din,
  output logic      dout
);

  logic [SYNC_STAGES-1:0] stage;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      stage <= {SYNC_STAGES{INIT}};
    else
      stage <= {stage[SYNC_STAGES-2:0], din};
  end

  // Change only once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
      dout <= INIT;
    else if (stage[SYNC_STAGES-1] == stage[SYNC_STAGES-2])
      dout <= stage[SYNC_STAGES-1];
  end

endmodule // pdmc_sync3

// *** hw/pdmc_cpu_side.sv ***
`timescale 1ns/1ps
module pdmc_cpu_side
  import pdmc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Power-down controller
  pdmc_if.host            bus,
  // Software register port
  input  wire logic [7:0] swAddr,
  input  wire logic [7:0] swWdata,
  input  wire logic       swWr,
  input  wire logic       swRd,
  output logic [7:0]      swRdata
);

  logic [7:0] pdcMirror;
  logic       rdPend;
  logic [2:0] cause;
  logic       wrPdc;
  logic       wrCmd;

  assign wrPdc = swWr && (swAddr == HOST_PDC_OFS);
  assign wrCmd = swWr && (swAddr == HOST_CMD_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Device register traffic; polls the register whenever not writing

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus.regAddr  <= PDC_OFFSET;
      bus.regWr    <= 1'b0;
      bus.regRd    <= 1'b0;
      bus.regWdata <= PDC_RESET;
    end
    else
    begin
      bus.regWr <= wrPdc;
      bus.regRd <= !wrPdc;
      if (wrPdc)
        bus.regWdata <= {swWdata[PDC_STBY_BIT], swWdata[PDC_FLOAT_BIT],
                         PDC_BIT5, PDC_ONES};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdPend    <= 1'b0;
      pdcMirror <= PDC_RESET;
    end
    else
    begin
      rdPend <= bus.regRd;
      if (rdPend)
        pdcMirror <= bus.regRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog run bit

  always_ff @(posedge clk)
  begin
    if (!nrst)
      bus.watchdogRun <= 1'b0;
    else if (bus.standbyActive)
      bus.watchdogRun <= 1'b0;
    // Stop the watchdog before setting either bit
    else if (wrPdc && (swWdata[PDC_STBY_BIT] || swWdata[PDC_FLOAT_BIT]))
      bus.watchdogRun <= 1'b0;
    else if (swWr && (swAddr == HOST_WDOG_OFS))
      bus.watchdogRun <= swWdata[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask and event commands

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus.cpuMask    <= 4'hF;
      bus.irqEnabled <= 1'b0;
    end
    else if (swWr && (swAddr == HOST_MASK_OFS))
    begin
      bus.cpuMask    <= swWdata[3:0];
      bus.irqEnabled <= swWdata[MASK_EN_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus.sleepExec  <= 1'b0;
      bus.nmiReq     <= 1'b0;
      bus.dmaAddrErr <= 1'b0;
    end
    else
    begin
      bus.sleepExec  <= wrCmd && swWdata[CMD_SLEEP_BIT] && !bus.cpuHalt;
      bus.nmiReq     <= wrCmd && swWdata[CMD_NMI_BIT];
      bus.dmaAddrErr <= wrCmd && swWdata[CMD_DMAE_BIT];
    end
  end

  // Request stays until the device reports it taken; a new one wins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus.irqReq  <= 1'b0;
      bus.irqPrio <= 4'h0;
    end
    else if (wrCmd && swWdata[CMD_IRQ_BIT])
    begin
      bus.irqReq  <= 1'b1;
      bus.irqPrio <= swWdata[CMD_PRIO_LSB +: 4];
    end
    else if (bus.excIrq)
      bus.irqReq <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake causes, write one to clear, a new cause wins

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cause <= 3'h0;
    else
    begin
      if (swWr && (swAddr == HOST_STAT_OFS))
        cause <= (cause & ~swWdata[2:0])
                 | {bus.excNmi, bus.excDma, bus.excIrq};
      else
        cause <= cause | {bus.excNmi, bus.excDma, bus.excIrq};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      swRdata <= 8'h00;
    else if (!swRd)
      swRdata <= 8'h00;
    else
    begin
      unique case (swAddr)
        HOST_WDOG_OFS: swRdata <= {7'h00, bus.watchdogRun};
        HOST_MASK_OFS: swRdata <= {3'h0, bus.irqEnabled, bus.cpuMask};
        HOST_CMD_OFS:  swRdata <= {bus.irqPrio, 2'h0, bus.irqReq, 1'b0};
        HOST_PDC_OFS:  swRdata <= pdcMirror;
        HOST_STAT_OFS: swRdata <= {2'h0, bus.porActive, bus.standbyActive,
                                   bus.cpuHalt, cause};
        default:       swRdata <= 8'h00;
      endcase
    end
  end

endmodule // pdmc_cpu_side

// *** sim/pdmc_asserts.sv ***
`timescale 1ns/1ps
module pdmc_asserts
  import pdmc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Interface signals
  input wire logic [31:0] regAddr,
  input wire logic        regRd,
  input wire logic        regWr,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic        sleepExec,
  input wire logic        irqReq,
  input wire logic [3:0]  irqPrio,
  input wire logic        irqEnabled,
  input wire logic [3:0]  cpuMask,
  input wire logic        nmiReq,
  input wire logic        dmaAddrErr,
  input wire logic        watchdogRun,
  input wire logic        cpuHalt,
  input wire logic        standbyActive,
  input wire logic        porActive,
  input wire logic        excIrq,
  input wire logic        excDma,
  input wire logic        excNmi,
  // Mode outputs of the device end
  input wire logic        clockRun,
  input wire logic        periphRun,
  input wire logic        portFloat
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic irqOk;
  logic asleep;
  assign irqOk = irqReq && irqEnabled && (irqPrio > cpuMask);
  // Pin reset excluded: it wins over every wake event
  assign asleep = cpuHalt && !standbyActive && !porActive;
  ////////////////////////////////////////////////////////////////////////
  sleep_entry_a: assert property (
    sleepExec && !cpuHalt && !porActive |=> cpuHalt)
    else $error("sleep instruction did not halt");
  sleep_clock_a: assert property (asleep |-> clockRun && periphRun)
    else $error("clock stopped in sleep");
  standby_halt_a: assert property (
    standbyActive |-> !clockRun && !periphRun)
    else $error("clock running in standby");
  irq_wake_a: assert property (
    asleep && irqOk && !nmiReq && !dmaAddrErr |=> excIrq && !cpuHalt)
    else $error("accepted interrupt did not wake");
  irq_cause_a: assert property (excIrq |-> $past(irqOk))
    else $error("wake by a refused interrupt");
  dma_wake_a: assert property (
    asleep && dmaAddrErr && !nmiReq |=> excDma && !cpuHalt)
    else $error("dma address error did not wake");
  standby_hold_a: assert property (
    standbyActive && !nmiReq && !porActive |=> standbyActive || porActive)
    else $error("standby left without nmi");
  nmi_exit_a: assert property (
    standbyActive && nmiReq |=> excNmi && !standbyActive)
    else $error("nmi did not end standby");
  pin_reset_a: assert property (porActive |-> !cpuHalt && !excIrq)
    else $error("pin reset did not end sleep");
  float_mode_a: assert property (portFloat |-> standbyActive)
    else $error("ports floating outside standby");
  wdog_order_a: assert property (
    regWr && regAddr == PDC_OFFSET
    && (regWdata[PDC_STBY_BIT] || regWdata[PDC_FLOAT_BIT]) |-> !watchdogRun)
    else $error("select bit written while watchdog runs");
  rsvd_read_a: assert property (
    regRd && regAddr == PDC_OFFSET |=> regRdata[5:0] == 6'h1F)
    else $error("reserved bits read wrong");
  cover property (excIrq);
  cover property (excDma);
  cover property (excNmi);
  cover property ($rose(standbyActive));
endmodule // pdmc_asserts

// *** sim/pdmc_power_down_ctrl_test.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin cmpCount++; if ((got) !== (exp)) begin failCount++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module pdmc_power_down_ctrl_test
  import pdmc_pkg::*;
;
  logic       clk;
  logic       nrst;
  logic       resetPinN;
  logic [7:0] swAddr;
  logic [7:0] swWdata;
  logic       swWr;
  logic       swRd;
  logic [7:0] swRdata;
  logic       clockRun;
  logic       periphRun;
  logic       portFloat;
  logic       ramHold;
  logic [7:0] expQ[$];
  logic [7:0] expV;
  logic       p1 = 1'b0;
  int         failCount = 0;
  int         cmpCount = 0;
  pdmc_if busIf ();
  pdmc_power_down_ctrl pdmc_power_down_ctrl_inst (
    .clk(clk), .nrst(nrst), .bus(busIf.dev), .resetPinN(resetPinN),
    .clockRun(clockRun), .periphRun(periphRun), .portFloat(portFloat),
    .ramHold(ramHold));
  pdmc_cpu_side pdmc_cpu_side_inst (
    .clk(clk), .nrst(nrst), .bus(busIf.host), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
  pdmc_asserts pdmc_asserts_inst (
    .clk(clk), .nrst(nrst), .regAddr(busIf.regAddr),
    .regRd(busIf.regRd), .regRdata(busIf.regRdata),
    .regWr(busIf.regWr), .regWdata(busIf.regWdata),
    .watchdogRun(busIf.watchdogRun),
    .sleepExec(busIf.sleepExec), .irqReq(busIf.irqReq),
    .irqPrio(busIf.irqPrio), .irqEnabled(busIf.irqEnabled),
    .cpuMask(busIf.cpuMask), .nmiReq(busIf.nmiReq),
    .dmaAddrErr(busIf.dmaAddrErr), .cpuHalt(busIf.cpuHalt),
    .standbyActive(busIf.standbyActive), .porActive(busIf.porActive),
    .excIrq(busIf.excIrq), .excDma(busIf.excDma),
    .excNmi(busIf.excNmi), .clockRun(clockRun),
    .periphRun(periphRun), .portFloat(portFloat));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
  endtask
  // Note the expectation as the read is issued
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    expQ.push_back(e);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
  endtask
  task automatic completeRun();
    $display("counts: %0d compared, %0d failed", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    p1 <= swRd;
    if (p1)
    begin
      expV = expQ.size() > 0 ? expQ.pop_front() : 8'hXX;
      `CHK(swRdata, expV)
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] v;
    logic [3:0] m;
    clk = 1'b0;
    nrst = 1'b0;
    resetPinN = 1'b1;
    swAddr = 8'h00;
    swWdata = 8'h00;
    swWr = 1'b0;
    swRd = 1'b0;
    void'($urandom(32'h4C06));
    tick(20);
    nrst <= 1'b1;
    rd(HOST_PDC_OFS, PDC_RESET);
    rd(HOST_STAT_OFS, 8'h00);
    $display("test reset done");
    // Host starts the watchdog before each write; writing a select bit stops it
    repeat (4)
    begin
      v = 8'($urandom());
      wr(HOST_WDOG_OFS, 8'h01);
      wr(HOST_PDC_OFS, v);
      tick(4);
      rd(HOST_PDC_OFS, {v[7:6], 1'b0, 5'h1F});
    end
    $display("test register done");
    m = 4'($urandom_range(13, 0));
    wr(HOST_PDC_OFS, 8'h1F);
    wr(HOST_MASK_OFS, {4'h0, m});
    wr(HOST_CMD_OFS, 8'h01);
    tick(4);
    rd(HOST_STAT_OFS, 8'h08);
    `CHK(clockRun, 1'b1)
    `CHK(portFloat, 1'b0)
    `CHK(ramHold, 1'b1)
    wr(HOST_CMD_OFS, 8'hF2);
    tick(6);
    rd(HOST_STAT_OFS, 8'h08);
    wr(HOST_CMD_OFS, {m, 4'h2});
    wr(HOST_MASK_OFS, {4'h1, m});
    rd(HOST_MASK_OFS, {4'h1, m});
    tick(6);
    rd(HOST_STAT_OFS, 8'h08);
    wr(HOST_CMD_OFS, {4'(m + 4'h1), 4'h2});
    tick(4);
    rd(HOST_STAT_OFS, 8'h01);
    wr(HOST_STAT_OFS, 8'h07);
    $display("test interrupt wake done");
    for (int k = 0; k < 2; k++)
    begin
      wr(HOST_CMD_OFS, 8'h01);
      tick(3);
      wr(HOST_CMD_OFS, k ? 8'h04 : 8'h08);
      tick(4);
      rd(HOST_STAT_OFS, k ? 8'h04 : 8'h02);
      wr(HOST_STAT_OFS, 8'h07);
    end
    $display("test dma and nmi wake done");
    wr(HOST_WDOG_OFS, 8'h01);
    wr(HOST_PDC_OFS, 8'hDF);
    tick(4);
    wr(HOST_CMD_OFS, 8'h01);
    tick(4);
    `CHK(portFloat, 1'b1)
    `CHK(clockRun, 1'b0)
    `CHK(ramHold, 1'b1)
    wr(HOST_CMD_OFS, 8'hFA);
    tick(6);
    rd(HOST_STAT_OFS, 8'h18);
    wr(HOST_CMD_OFS, 8'h04);
    tick(4);
    rd(HOST_STAT_OFS, 8'h04);
    $display("test standby done");
    // Pending interrupt would wake the next sleep at once
    wr(HOST_MASK_OFS, 8'h0F);
    rd(HOST_CMD_OFS, 8'hF2);
    wr(HOST_STAT_OFS, 8'h07);
    wr(HOST_PDC_OFS, 8'h5F);
    wr(HOST_CMD_OFS, 8'h01);
    tick(3);
    `CHK(portFloat, 1'b0)
    `CHK(ramHold, 1'b1)
    resetPinN <= 1'b0;
    tick(8);
    rd(HOST_STAT_OFS, 8'h20);
    resetPinN <= 1'b1;
    tick(8);
    rd(HOST_PDC_OFS, PDC_RESET);
    `CHK(ramHold, 1'b0)
    $display("test pin reset done");
    for (int i = 0; i < 50 && expQ.size() > 0; i++)
      tick(1);
    if (expQ.size() > 0)
      failCount++;
    completeRun();
  end
endmodule // pdmc_power_down_ctrl_test
